// file: asp_pkg.sv
// Purpose: shared constants and types for the async static memory host port
// Assumes: mclk at 250 MHz
// Notes: times in ns, cycle counts derived from them
package asp_pkg;
  // ==========================================================
  // clock
  localparam int CLK_PERIOD_NS = 4;
  // ==========================================================
  // pin timing, figures in ns
  localparam int T_WLWH_NS = 20;
  localparam int T_DVWH_NS = 15;
  localparam int T_WHWL_NS = 5;
  localparam int T_AVQV_NS = 25;
  localparam int T_GHQZ_NS = 9;
  localparam int T_SHQZ_NS = 10;
  // ==========================================================
  // derived cycle counts, least times rounded up
  localparam int WP_CYC = (T_WLWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC = (T_DVWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (T_WHWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_AVQV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_NS = (T_GHQZ_NS > T_SHQZ_NS) ? T_GHQZ_NS : T_SHQZ_NS;
  localparam int TURN_CYC = (HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // ==========================================================
  // one-hot sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WSET = 7'h02,
    ST_WPUL = 7'h04,
    ST_WREC = 7'h08,
    ST_RACC = 7'h10,
    ST_RDON = 7'h20,
    ST_TURN = 7'h40
  } asp_st_t;
endpackage : asp_pkg

// file: asp_sync.sv
// Purpose: two-stage synchroniser for the byte bus input
// Assumes: input is asynchronous to mclk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module asp_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // stages
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } asp_sync_st_t;
  asp_sync_st_t s_r;
  asp_sync_st_t s_nxt;
  always_comb begin
    s_nxt.meta = d;
    s_nxt.q = s_r.meta;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q = s_r.q;
endmodule : asp_sync

// file: asp_host.sv
// Purpose: host controller driving a 32K x 8 asynchronous static memory
// Assumes: one request at a time, pins stable across the board
// Notes: bus pins split into in, out and active-low drive enable
`timescale 1ns/1ns
module asp_host #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8,
  parameter bit HAS_EN = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_we,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  // user answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // memory pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_sel_n,
  output logic mem_en,
  output logic mem_wr_n,
  output logic mem_oe_n,
  input wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_n
);
  // ==========================================================
  // state record
  typedef struct packed {
    asp_pkg::asp_st_t st;
    logic [asp_pkg::CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rdat;
    logic sel_n;
    logic en;
    logic wr_n;
    logic oe_n;
    logic dq_oe_n;
    logic rvalid;
  } asp_state_t;

  localparam logic [asp_pkg::CNT_W-1:0] WP_N = asp_pkg::CNT_W'(asp_pkg::WP_CYC);
  localparam logic [asp_pkg::CNT_W-1:0] WR_N = asp_pkg::CNT_W'(asp_pkg::WR_CYC);
  localparam logic [asp_pkg::CNT_W-1:0] RD_N = asp_pkg::CNT_W'(asp_pkg::ACC_CYC + asp_pkg::SYNC_STAGES);
  localparam logic [asp_pkg::CNT_W-1:0] TN_N = asp_pkg::CNT_W'(asp_pkg::TURN_CYC);

  asp_state_t s_r;
  asp_state_t s_nxt;
  logic [DATA_W-1:0] dq_sync;

  // ==========================================================
  // bus input synchroniser
  asp_sync #(.W(DATA_W)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d(mem_dq_i),
    .q(dq_sync)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    case (s_r.st)
      asp_pkg::ST_IDLE: begin
        s_nxt.sel_n = 1'b1;
        s_nxt.en = 1'b0;
        s_nxt.wr_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.dq_oe_n = 1'b1;
        if (req_valid) begin
          s_nxt.addr = req_addr;
          s_nxt.sel_n = 1'b0;
          s_nxt.en = 1'b1;
          if (req_we) begin
            s_nxt.wdat = req_wdata;
            s_nxt.dq_oe_n = 1'b0;
            s_nxt.st = asp_pkg::ST_WSET;
          end else begin
            s_nxt.oe_n = 1'b0;
            s_nxt.cnt = RD_N;
            s_nxt.st = asp_pkg::ST_RACC;
          end
        end
      end
      asp_pkg::ST_WSET: begin
        s_nxt.wr_n = 1'b0;
        s_nxt.cnt = WP_N;
        s_nxt.st = asp_pkg::ST_WPUL;
      end
      asp_pkg::ST_WPUL: begin
        s_nxt.cnt = s_r.cnt - asp_pkg::CNT_ONE;
        if (s_r.cnt == asp_pkg::CNT_ONE) begin
          s_nxt.wr_n = 1'b1;
          s_nxt.cnt = WR_N;
          s_nxt.st = asp_pkg::ST_WREC;
        end
      end
      asp_pkg::ST_WREC: begin
        s_nxt.sel_n = 1'b1;
        s_nxt.en = 1'b0;
        s_nxt.dq_oe_n = 1'b1;
        s_nxt.cnt = s_r.cnt - asp_pkg::CNT_ONE;
        if (s_r.cnt == asp_pkg::CNT_ONE) begin
          s_nxt.st = asp_pkg::ST_IDLE;
        end
      end
      asp_pkg::ST_RACC: begin
        s_nxt.cnt = s_r.cnt - asp_pkg::CNT_ONE;
        if (s_r.cnt == asp_pkg::CNT_ONE) begin
          s_nxt.st = asp_pkg::ST_RDON;
        end
      end
      asp_pkg::ST_RDON: begin
        s_nxt.rdat = dq_sync;
        s_nxt.rvalid = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.sel_n = 1'b1;
        s_nxt.en = 1'b0;
        s_nxt.cnt = TN_N;
        s_nxt.st = asp_pkg::ST_TURN;
      end
      asp_pkg::ST_TURN: begin
        s_nxt.cnt = s_r.cnt - asp_pkg::CNT_ONE;
        if (s_r.cnt == asp_pkg::CNT_ONE) begin
          s_nxt.st = asp_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = asp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: asp_pkg::ST_IDLE, cnt: '0, addr: '0, wdat: '0, rdat: '0,
               sel_n: 1'b1, en: 1'b0, wr_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1, rvalid: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign req_ready = (s_r.st == asp_pkg::ST_IDLE);
  assign rsp_valid = s_r.rvalid;
  assign rsp_rdata = s_r.rdat;
  assign mem_addr = s_r.addr;
  assign mem_sel_n = s_r.sel_n;
  assign mem_en = HAS_EN ? s_r.en : 1'b1;
  assign mem_wr_n = s_r.wr_n;
  assign mem_oe_n = s_r.oe_n;
  assign mem_dq_o = s_r.wdat;
  assign mem_dq_oe_n = s_r.dq_oe_n;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_write_pins: assert property (
    !mem_wr_n |-> !mem_sel_n && mem_en && !mem_dq_oe_n && mem_oe_n)
    else $error("write strobe low without full write qualification");
  a_read_pins: assert property (
    !mem_oe_n |-> mem_wr_n && !mem_sel_n && mem_en && mem_dq_oe_n)
    else $error("output enable low outside a read");
  a_addr_hold: assert property (
    $changed(mem_addr) |-> mem_wr_n && $past(mem_wr_n))
    else $error("address moved during active write");
  a_no_contend: assert property (
    !mem_dq_oe_n |-> mem_oe_n ##1 (mem_dq_oe_n || mem_oe_n))
    else $error("host drives bus while memory output enabled");
  a_pulse_width: assert property (
    $fell(mem_wr_n) |-> !mem_wr_n [*5] ##1 mem_wr_n && !mem_dq_oe_n)
    else $error("write pulse length or data hold wrong");
  a_read_time: assert property (
    $fell(mem_oe_n) |-> ##10 rsp_valid)
    else $error("read answer not at fixed latency");
  a_turn_gap: assert property (
    rsp_valid |-> mem_dq_oe_n [*4])
    else $error("bus driven too soon after read");
  a_idle_quiet: assert property (
    req_ready |-> mem_sel_n && mem_wr_n && mem_oe_n && mem_dq_oe_n)
    else $error("pins active while sequencer idle");
  a_data_stable: assert property (
    $fell(mem_wr_n) |-> $stable(mem_dq_o) [*5])
    else $error("write data moved during write pulse");
  a_write_end: assert property (
    $rose(mem_wr_n) |-> ##1 (mem_sel_n && mem_dq_oe_n))
    else $error("select or bus not released after write");

  c_write: cover property ($fell(mem_wr_n) ##[1:10] $rose(mem_wr_n));
  c_read: cover property (rsp_valid);
  c_rd_then_wr: cover property (rsp_valid ##[1:20] !mem_wr_n);
  c_back_writes: cover property ($rose(mem_wr_n) ##[1:12] $fell(mem_wr_n));
  c_wr_then_rd: cover property ($rose(mem_wr_n) ##[1:12] $fell(mem_oe_n));
endmodule : asp_host

// file: asp_mem_model.sv
// Purpose: behavioural 32K x 8 asynchronous static memory
// Assumes: pins come from the host port
// Notes: released bus level is made by the bench
`timescale 1ns/1ns
module asp_mem_model (
  // memory pins
  input wire logic [14:0] addr,
  input wire logic sel_n,
  input wire logic en,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [7:0] din,
  // read side
  output logic [7:0] q,
  output logic q_on,
  output logic addr_err
);
  // ==========================================
  // array and decode
  logic [7:0] mem [0:32767];
  logic wact;
  assign wact = !sel_n && en && !wr_n;
  assign q_on = !sel_n && en && wr_n && !oe_n;
  assign q = mem[addr];
  // ==========================================
  // first deasserting edge latches data
  always @(negedge wact) begin
    mem[addr] = din;
  end
  // address moving in a write
  initial addr_err = 1'b0;
  always @(addr) begin
    if (wact) begin
      addr_err = 1'b1;
    end
  end
endmodule : asp_mem_model

// file: testbench.sv
// Purpose: self-checking bench for the host port
// Assumes: inputs driven at falling edge
// Notes: random traffic from a fixed seed
`timescale 1ns/1ns
module testbench;
  logic mclk, rstn, req_valid, req_ready, req_we, rsp_valid;
  logic [14:0] req_addr, mem_addr, a;
  logic [7:0] req_wdata, rsp_rdata, dq_o, dq_wire, q, d;
  logic [7:0] pat = 8'h5a;
  logic sel_n, en, wr_n, oe_n, dq_oe_n, q_on, addr_err, we;
  logic sel_n2, en2, wr_n2, oe_n2, dq_oe_n2, req_ready2, rsp_valid2, same_pins;
  logic [14:0] mem_addr2;
  logic [7:0] rsp_rdata2, dq_o2;
  logic [7:0] ref_mem [int];
  int bad_count, num_checks, i;
  integer seed;
  // ==========================================
  // design, memory and bus wire
  asp_host dut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_sel_n(sel_n), .mem_en(en),
    .mem_wr_n(wr_n), .mem_oe_n(oe_n), .mem_dq_i(dq_wire), .mem_dq_o(dq_o),
    .mem_dq_oe_n(dq_oe_n));
  asp_mem_model mem (.addr(mem_addr), .sel_n(sel_n), .en(en), .wr_n(wr_n), .oe_n(oe_n),
    .din(dq_wire), .q(q), .q_on(q_on), .addr_err(addr_err));
  asp_host #(.HAS_EN(1'b0)) dut_noen (.mclk(mclk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready2), .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid2), .rsp_rdata(rsp_rdata2), .mem_addr(mem_addr2), .mem_sel_n(sel_n2),
    .mem_en(en2), .mem_wr_n(wr_n2), .mem_oe_n(oe_n2), .mem_dq_i(dq_wire), .mem_dq_o(dq_o2),
    .mem_dq_oe_n(dq_oe_n2));
  assign same_pins = ({mem_addr2, dq_o2, sel_n2, wr_n2, oe_n2, dq_oe_n2, req_ready2, rsp_valid2} ===
    {mem_addr, dq_o, sel_n, wr_n, oe_n, dq_oe_n, req_ready, rsp_valid});
  assign dq_wire = !dq_oe_n ? dq_o : (q_on ? q : pat);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) pat <= ~pat;
  // ==========================================
  // checking helpers
  function automatic logic [7:0] exp_rd(input logic [14:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : 8'hxx;
  endfunction : exp_rd
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // one request; a read waits for its answer, a write returns one cycle after the request
  task automatic access(input logic w, input logic [14:0] x, input logic [7:0] v);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("request ready", 8'h01, {7'h0, req_ready});
    req_valid = 1'b1;
    req_we = w;
    req_addr = x;
    req_wdata = v;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (!w && rsp_valid !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (!w) begin
      chk("read answer", 8'h01, {7'h0, rsp_valid});
      chk("read latency", 8'(asp_pkg::ACC_CYC + asp_pkg::SYNC_STAGES + 1), 8'(n));
      chk("read data", exp_rd(x), rsp_rdata);
      chk("no-enable read data", exp_rd(x), rsp_rdata2);
    end else begin
      ref_mem[x] = v;
    end
  endtask : access
  // ==========================================
  // pin monitor
  always @(negedge mclk) begin
    if (rstn) begin
      if (!dq_oe_n) chk("oe_n while driving", 8'h01, {7'h0, oe_n});
      if (!wr_n) chk("write qualifiers", 8'h02, {6'h0, en, sel_n});
      chk("address held in write", 8'h00, {7'h0, addr_err});
      chk("no-enable variant enable", 8'h01, {7'h0, en2});
      chk("no-enable variant pins", 8'h01, {7'h0, same_pins});
    end
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  // ==========================================
  // main sequence
  initial begin
    seed = 42;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_we = 1'b0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    chk("idle select", 8'h01, {7'h0, sel_n});
    chk("idle enable", 8'h00, {7'h0, en});
    access(1'b1, 15'h0000, 8'ha5);
    access(1'b1, 15'h7fff, 8'h3c);
    access(1'b1, 15'h0000, 8'h5a);
    access(1'b0, 15'h0000, 8'h00);
    access(1'b0, 15'h7fff, 8'h00);
    for (i = 0; i < 60; i++) begin
      a = 15'($random(seed)) & 15'h000f;
      d = 8'($random(seed));
      we = 1'($random(seed));
      if (!ref_mem.exists(a)) we = 1'b1;
      access(we, a, d);
    end
    // reset in mid-run, memory keeps its contents
    repeat (20) @(negedge mclk);
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    chk("reset select", 8'h01, {7'h0, sel_n});
    chk("reset enable", 8'h00, {7'h0, en});
    chk("reset ready", 8'h01, {7'h0, req_ready});
    access(1'b1, 15'h0005, 8'hc3);
    access(1'b0, 15'h0005, 8'h00);
    access(1'b0, 15'h7fff, 8'h00);
    print_verdict;
  end
endmodule : testbench
